// ==== src/dcache_front.v ====
// Data cache front end: banked load pairing, miss tracking and write combining.
//
// Summary of operation
// - Sixteen miss entries, prefetches share the pool.
// - Full tracker holds requests until entry frees.
// - Pending misses are issued oldest first.
// - At most eight distinct lines toward memory.
// - Same-line requests share one memory slot.
// - Line length is 64 bytes everywhere.
// - Prefetch matching pending store waits for store.
// - Write-intent prefetch fills line as modified when it made the line's memory request itself.
// - Stores within one line merge in buffer.
// - Sixteen banks, 16 bytes each, address-selected.
// - Conflict only: same bank, different index.
// - Loads complete strictly in program order.
// - Two loads per cycle, one on conflict.
`include "dcache_regs.vh"
module dcache_front (
  input wire i_clock,
  input wire i_resetn,
  input wire i_ld0_valid,
  input wire [`ADDR_W-1:0] i_ld0_addr,
  input wire i_ld1_valid,
  input wire [`ADDR_W-1:0] i_ld1_addr,
  output wire o_ld0_done,
  output wire o_ld1_done,
  output reg o_conflict_q,
  output reg [`BANK_W-1:0] o_ld0_bank_q,
  output reg [`IDX_W-1:0] o_ld0_index_q,
  output reg [`BANK_W-1:0] o_ld1_bank_q,
  output reg [`IDX_W-1:0] o_ld1_index_q,
  input wire i_miss_valid,
  input wire [`ADDR_W-1:0] i_miss_addr,
  input wire i_miss_prefetch,
  input wire i_miss_write_intent,
  output wire o_miss_ready,
  output wire o_mem_req_valid,
  output wire [`ADDR_W-1:0] o_mem_req_addr,
  output wire [`MISS_PTR_W-1:0] o_mem_req_tag,
  input wire i_mem_req_ready,
  input wire i_mem_fill_valid,
  input wire [`MISS_PTR_W-1:0] i_mem_fill_tag,
  output reg o_fill_valid_q,
  output reg [`ADDR_W-1:0] o_fill_addr_q,
  output reg o_fill_modified_q,
  input wire i_st_valid,
  input wire [`ADDR_W-1:0] i_st_addr,
  input wire [63:0] i_st_data,
  input wire [7:0] i_st_bytes,
  output wire o_st_ready,
  output reg o_wcb_valid_q,
  output reg [`ADDR_W-1:0] o_wcb_addr_q,
  output reg [`WCB_DATA_W-1:0] o_wcb_data_q,
  output reg [`LINE_BYTES-1:0] o_wcb_bytes_q,
  input wire i_wcb_drain_ready,
  output wire [`MEM_CNT_W:0] o_inflight_lines
);
  // ==========================================================
  // Reset release
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // ==========================================================
  // Banked load pairing
  // bank index fields
  wire [`BANK_W-1:0] bank0 = i_ld0_addr[`BANK_LSB+`BANK_W-1:`BANK_LSB];
  wire [`BANK_W-1:0] bank1 = i_ld1_addr[`BANK_LSB+`BANK_W-1:`BANK_LSB];
  wire [`IDX_W-1:0] idx0 = i_ld0_addr[`IDX_LSB+`IDX_W-1:`IDX_LSB];
  wire [`IDX_W-1:0] idx1 = i_ld1_addr[`IDX_LSB+`IDX_W-1:`IDX_LSB];
  wire conflict = i_ld0_valid & i_ld1_valid & (bank0 == bank1) & (idx0 != idx1);
  assign o_ld0_done = i_ld0_valid;
  assign o_ld1_done = i_ld1_valid & i_ld0_valid & ~conflict;
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_conflict_q <= 1'b0;
      o_ld0_bank_q <= {`BANK_W{1'b0}};
      o_ld0_index_q <= {`IDX_W{1'b0}};
      o_ld1_bank_q <= {`BANK_W{1'b0}};
      o_ld1_index_q <= {`IDX_W{1'b0}};
    end else begin
      o_conflict_q <= conflict;
      o_ld0_bank_q <= bank0;
      o_ld0_index_q <= idx0;
      o_ld1_bank_q <= bank1;
      o_ld1_index_q <= idx1;
    end
  end

  // ==========================================================
  // Miss tracking
  wire [`LINE_W-1:0] miss_line = i_miss_addr[`ADDR_W-1:`LINE_OFS_W];
  wire [`MISS_ENTRIES-1:0] busy, sent, wi, pf, alloc, issue, free, same_sent;
  wire [`LINE_W-1:0] line [0:`MISS_ENTRIES-1];
  reg [`MISS_PTR_W-1:0] head_q, tail_q, send_q;
  reg [`MISS_PTR_W:0] count_q;
  reg [`MEM_CNT_W:0] lines_out;
  reg [`MISS_ENTRIES-1:0] first_of_line;
  integer a, b;
  always @* begin
    lines_out = {(`MEM_CNT_W+1){1'b0}};
    first_of_line = {`MISS_ENTRIES{1'b0}};
    for (a = 0; a < `MISS_ENTRIES; a = a + 1) begin
      first_of_line[a] = busy[a] & sent[a];
      for (b = 0; b < a; b = b + 1) begin
        if (busy[b] & sent[b] & (line[b] == line[a])) first_of_line[a] = 1'b0;
      end
      if (first_of_line[a]) lines_out = lines_out + 1'b1;
    end
  end
  assign o_inflight_lines = lines_out;

  wire st_line_hit = (o_wcb_valid_q & (o_wcb_addr_q[`ADDR_W-1:`LINE_OFS_W] == miss_line)) |
    (i_st_valid & (i_st_addr[`ADDR_W-1:`LINE_OFS_W] == miss_line));
  assign o_miss_ready = (count_q != `MISS_ENTRIES) & ~(i_miss_prefetch & st_line_hit);
  wire take = i_miss_valid & o_miss_ready;

  wire send_busy = busy[send_q] & ~sent[send_q];
  wire send_shares = |same_sent;
  wire send_ok = send_busy & (send_shares | (lines_out < `MEM_LIMIT));
  assign o_mem_req_valid = send_ok & ~send_shares;
  assign o_mem_req_addr = {line[send_q], {`LINE_OFS_W{1'b0}}};
  assign o_mem_req_tag = send_q;
  wire send_fire = send_ok & (send_shares | i_mem_req_ready);

  // A same-line entry asked memory for nothing, so it retires as soon as it is
  // the oldest. Limitation: a fill that lands in the cycle such an entry retires
  // is ignored, so memory must space its fills apart.
  reg [`MISS_ENTRIES-1:0] silent_q;
  wire head_done = busy[head_q] & sent[head_q];
  wire fill_real = i_mem_fill_valid & head_done & ~silent_q[head_q] &
    (line[i_mem_fill_tag] == line[head_q]);
  wire fill_head = fill_real | (head_done & silent_q[head_q]);

  genvar g;
  generate
    for (g = 0; g < `MISS_ENTRIES; g = g + 1) begin : g_ent
      assign alloc[g] = take & (tail_q == g);
      assign issue[g] = send_fire & (send_q == g);
      assign same_sent[g] = busy[g] & sent[g] & (line[g] == line[send_q]);
      assign free[g] = busy[g] & (head_q == g) & sent[g];
      miss_entry u_ent (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_alloc(alloc[g]),
        .i_line(miss_line),
        .i_write_intent(i_miss_write_intent),
        .i_prefetch(i_miss_prefetch),
        .i_issue(issue[g]),
        .i_free(free[g] & fill_head),
        .o_busy_q(busy[g]),
        .o_sent_q(sent[g]),
        .o_line_q(line[g]),
        .o_write_intent_q(wi[g]),
        .o_prefetch_q(pf[g])
      );
    end
  endgenerate

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      silent_q <= {`MISS_ENTRIES{1'b0}};
    end else begin
      silent_q <= (silent_q & ~alloc) | (issue & {`MISS_ENTRIES{send_shares}});
    end
  end

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      head_q <= {`MISS_PTR_W{1'b0}};
      tail_q <= {`MISS_PTR_W{1'b0}};
      send_q <= {`MISS_PTR_W{1'b0}};
      count_q <= {(`MISS_PTR_W+1){1'b0}};
      o_fill_valid_q <= 1'b0;
      o_fill_addr_q <= {`ADDR_W{1'b0}};
      o_fill_modified_q <= 1'b0;
    end else begin
      if (take) tail_q <= tail_q + 1'b1;
      if (send_fire) send_q <= send_q + 1'b1;
      if (fill_head) head_q <= head_q + 1'b1;
      if (take & ~fill_head) count_q <= count_q + 1'b1;
      else if (~take & fill_head) count_q <= count_q - 1'b1;
      o_fill_valid_q <= fill_real;
      o_fill_addr_q <= {line[head_q], {`LINE_OFS_W{1'b0}}};
      o_fill_modified_q <= wi[head_q];
    end
  end

  // ==========================================================
  // Write combining buffer
  // A store to another line must wait for the current line to drain; this keeps
  // store order and stalls a line change only while i_wcb_drain_ready is low.
  wire st_same = o_wcb_valid_q & (o_wcb_addr_q[`ADDR_W-1:`LINE_OFS_W] ==
    i_st_addr[`ADDR_W-1:`LINE_OFS_W]);
  wire drain = o_wcb_valid_q & i_wcb_drain_ready & ~(i_st_valid & st_same);
  assign o_st_ready = ~o_wcb_valid_q | st_same | drain;
  wire st_take = i_st_valid & o_st_ready;
  wire [2:0] qw = i_st_addr[5:3];
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_wcb_valid_q <= 1'b0;
      o_wcb_addr_q <= {`ADDR_W{1'b0}};
      o_wcb_data_q <= {`WCB_DATA_W{1'b0}};
      o_wcb_bytes_q <= {`LINE_BYTES{1'b0}};
    end else if (st_take) begin : wcb_merge
      integer k;
      o_wcb_valid_q <= 1'b1;
      o_wcb_addr_q <= {i_st_addr[`ADDR_W-1:`LINE_OFS_W], {`LINE_OFS_W{1'b0}}};
      if (!st_same) o_wcb_bytes_q <= {`LINE_BYTES{1'b0}};
      for (k = 0; k < 8; k = k + 1) begin
        if (i_st_bytes[k]) begin
          o_wcb_data_q[qw*64+k*8 +: 8] <= i_st_data[k*8 +: 8];
          o_wcb_bytes_q[qw*8+k] <= 1'b1;
        end else if (!st_same) begin
          o_wcb_bytes_q[qw*8+k] <= 1'b0;
        end
      end
    end else if (drain) begin
      o_wcb_valid_q <= 1'b0;
      o_wcb_bytes_q <= {`LINE_BYTES{1'b0}};
    end
  end
endmodule

// ==== include/dcache_regs.vh ====
// Constants of the data cache front end.
`ifndef DCACHE_REGS_VH
`define DCACHE_REGS_VH
`define ADDR_W 32
`define LINE_BYTES 64
`define LINE_OFS_W 6
`define BANK_LSB 4
`define BANK_W 4
`define NUM_BANKS 16
`define BANK_BYTES 16
`define IDX_LSB 6
`define IDX_W 6
`define LINE_W 26
`define MISS_ENTRIES 16
`define MISS_PTR_W 4
`define MEM_LIMIT 8
`define MEM_CNT_W 4
`define WCB_DATA_W 512
`endif

// ==== src/miss_entry.v ====
// One miss-tracking entry: holds a line address, its intent and its phase.
`include "dcache_regs.vh"
module miss_entry (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_alloc,
  input wire [`LINE_W-1:0] i_line,
  input wire i_write_intent,
  input wire i_prefetch,
  input wire i_issue,
  input wire i_free,
  output reg o_busy_q,
  output reg o_sent_q,
  output reg [`LINE_W-1:0] o_line_q,
  output reg o_write_intent_q,
  output reg o_prefetch_q
);
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy_q <= 1'b0;
      o_sent_q <= 1'b0;
      o_line_q <= {`LINE_W{1'b0}};
      o_write_intent_q <= 1'b0;
      o_prefetch_q <= 1'b0;
    end else if (i_alloc) begin
      o_busy_q <= 1'b1;
      o_sent_q <= 1'b0;
      o_line_q <= i_line;
      o_write_intent_q <= i_write_intent;
      o_prefetch_q <= i_prefetch;
    end else if (i_free) begin
      o_busy_q <= 1'b0;
      o_sent_q <= 1'b0;
    end else if (i_issue) begin
      o_sent_q <= 1'b1;
    end
  end
endmodule

// ==== verif/dcache_front_props.sv ====
// Port-level assertions of the data cache front end.
`include "dcache_regs.vh"
module dcache_front_props (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_ld0_valid,
  input wire logic [31:0] i_ld0_addr,
  input wire logic i_ld1_valid,
  input wire logic [31:0] i_ld1_addr,
  input wire logic o_ld0_done,
  input wire logic o_ld1_done,
  input wire logic o_mem_req_valid,
  input wire logic [31:0] o_mem_req_addr,
  input wire logic i_mem_req_ready,
  input wire logic i_mem_fill_valid,
  input wire logic o_fill_valid_q,
  input wire logic [31:0] o_fill_addr_q,
  input wire logic o_wcb_valid_q,
  input wire logic i_wcb_drain_ready,
  input wire logic [4:0] o_inflight_lines
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  // ==========================================
  // Load pairing and memory side timing
  a_ld0_done: assert property (o_ld0_done == i_ld0_valid)
    else $error("older load not completed");
  a_ld1_order: assert property (o_ld1_done |-> o_ld0_done)
    else $error("younger load passed older");
  a_pair_rate: assert property (i_ld0_valid && i_ld1_valid |-> o_ld1_done ==
    !(i_ld0_addr[7:4] == i_ld1_addr[7:4] && i_ld0_addr[11:6] != i_ld1_addr[11:6]))
    else $error("load pair rate wrong");
  a_mem_limit: assert property (o_inflight_lines <= `MEM_LIMIT)
    else $error("too many lines in flight");
  a_req_hold: assert property (o_mem_req_valid && !i_mem_req_ready |=>
    o_mem_req_valid && $stable(o_mem_req_addr)) else $error("request dropped");
  a_req_align: assert property (o_mem_req_valid |-> o_mem_req_addr[5:0] == 6'h00)
    else $error("request not line aligned");
  a_fill_cause: assert property (o_fill_valid_q |-> $past(i_mem_fill_valid))
    else $error("fill without memory answer");
  a_fill_align: assert property (o_fill_valid_q |-> o_fill_addr_q[5:0] == 6'h00)
    else $error("fill not line aligned");
  a_wcb_hold: assert property (o_wcb_valid_q && !i_wcb_drain_ready |=> o_wcb_valid_q)
    else $error("buffer lost before drain");
endmodule
bind dcache_front dcache_front_props u_props (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_ld0_valid(i_ld0_valid), .i_ld0_addr(i_ld0_addr), .i_ld1_valid(i_ld1_valid),
  .i_ld1_addr(i_ld1_addr), .o_ld0_done(o_ld0_done), .o_ld1_done(o_ld1_done),
  .o_mem_req_valid(o_mem_req_valid), .o_mem_req_addr(o_mem_req_addr),
  .i_mem_req_ready(i_mem_req_ready), .i_mem_fill_valid(i_mem_fill_valid),
  .o_fill_valid_q(o_fill_valid_q), .o_fill_addr_q(o_fill_addr_q),
  .o_wcb_valid_q(o_wcb_valid_q), .i_wcb_drain_ready(i_wcb_drain_ready),
  .o_inflight_lines(o_inflight_lines));

// ==== verif/mem_model.sv ====
// Memory side model: takes line requests and returns fills oldest first.
module mem_model (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_req_valid,
  input wire logic [3:0] i_req_tag,
  input wire logic i_accept,
  input wire logic i_return,
  output logic o_ready,
  output logic o_fill_valid,
  output logic [3:0] o_fill_tag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] tags[$];
  logic [1:0] gap_q;
  assign o_ready = i_accept;
  // Fills are spaced four cycles apart so the tracker sees slow memory.
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tags.delete();
      gap_q <= 2'h0;
      o_fill_valid <= 1'b0;
      o_fill_tag <= 4'h0;
    end else begin
      if (i_req_valid && i_accept)
        tags.push_back(i_req_tag);
      gap_q <= gap_q + 2'h1;
      o_fill_valid <= 1'b0;
      o_fill_tag <= ~o_fill_tag;
      if (i_return && gap_q == 2'h0 && tags.size() > 0) begin
        o_fill_valid <= 1'b1;
        o_fill_tag <= tags.pop_front();
      end
    end
  end
endmodule

// ==== verif/dcache_front_tb_top.sv ====
// Self-checking bench of the data cache front end.
`include "dcache_regs.vh"
module dcache_front_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_resetn, i_ld0_valid, i_ld1_valid, i_miss_valid, i_miss_prefetch, ret;
  logic i_miss_write_intent, i_mem_req_ready, i_mem_fill_valid, i_st_valid, i_wcb_drain_ready;
  logic o_ld0_done, o_ld1_done, o_conflict_q, o_miss_ready, o_mem_req_valid, o_fill_valid_q;
  logic o_fill_modified_q, o_st_ready, o_wcb_valid_q, accept;
  logic [31:0] i_ld0_addr, i_ld1_addr, i_miss_addr, i_st_addr, o_mem_req_addr, seed, a;
  logic [31:0] o_fill_addr_q, o_wcb_addr_q;
  logic [3:0] o_ld0_bank_q, o_ld1_bank_q, o_mem_req_tag, i_mem_fill_tag;
  logic [5:0] o_ld0_index_q, o_ld1_index_q;
  logic [63:0] i_st_data, o_wcb_bytes_q, xb;
  logic [7:0] i_st_bytes;
  logic [511:0] o_wcb_data_q, xd, xm;
  logic [4:0] o_inflight_lines;
  logic [20:0] ldq[$];
  logic [32:0] fq[$];
  int miscompares, check_count, cyc, n;
  dcache_front dut (.*);
  mem_model u_mem (.i_clock(i_clock), .i_resetn(i_resetn), .i_req_valid(o_mem_req_valid),
    .i_req_tag(o_mem_req_tag), .i_accept(accept), .i_return(ret), .o_ready(i_mem_req_ready),
    .o_fill_valid(i_mem_fill_valid), .o_fill_tag(i_mem_fill_tag));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  function automatic [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input [511:0] got, input [511:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic ld(input [31:0] a0, input [31:0] a1);
    @(posedge i_clock);
    {i_ld0_valid, i_ld1_valid, i_ld0_addr, i_ld1_addr} <= {2'b11, a0, a1};
    @(posedge i_clock);
    ldq.push_back({a0[7:4] == a1[7:4] && a0[11:6] != a1[11:6], a0[7:4], a0[11:6],
      a1[7:4], a1[11:6]});
  endtask
  task automatic miss(input [31:0] ad, input pf, input wi);
    @(posedge i_clock);
    {i_miss_valid, i_miss_addr, i_miss_prefetch, i_miss_write_intent} <= {1'b1, ad, pf, wi};
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_miss_ready !== 1'b1 && n < 300);
    @(posedge i_clock);
    fq.push_back({wi, ad[31:6], 6'h00});
    i_miss_valid <= 1'b0;
  endtask
  task automatic st(input [31:0] ad, input [63:0] d, input [7:0] be);
    @(posedge i_clock);
    {i_st_valid, i_st_addr, i_st_data, i_st_bytes} <= {1'b1, ad, d, be};
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_st_ready !== 1'b1 && n < 300);
    @(posedge i_clock);
    i_st_valid <= 1'b0;
    for (int j = 0; j < 8; j++)
      if (be[j]) begin
        xb[ad[5:3] * 8 + j] = 1'b1;
        xm[(ad[5:3] * 8 + j) * 8 +: 8] = 8'hff;
        xd[(ad[5:3] * 8 + j) * 8 +: 8] = d[j * 8 +: 8];
      end
  endtask
  // ==========================================
  // Result watcher
  always @(negedge i_clock) begin
    if (ldq.size() > 0)
      chk({o_conflict_q, o_ld0_bank_q, o_ld0_index_q, o_ld1_bank_q, o_ld1_index_q},
        ldq.pop_front());
    if (o_fill_valid_q === 1'b1)
      chk({o_fill_modified_q, o_fill_addr_q}, fq.size() > 0 ? fq.pop_front() : '1);
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    {i_ld0_valid, i_ld1_valid, i_miss_valid, i_st_valid, i_wcb_drain_ready, accept, ret} = '0;
    {i_ld0_addr, i_ld1_addr, i_miss_addr, i_st_addr, i_st_data, i_st_bytes} = '0;
    {i_miss_prefetch, i_miss_write_intent, cyc, xb, xd, xm} = '0;
    seed = 32'h0bcd;
    i_resetn = 1'b0;
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clock);
    ld(32'h0000_0010, 32'h0000_0110);
    ld(32'h0000_0010, 32'h0000_0018);
    for (int k = 0; k < 30; k++) begin
      seed = nx(seed);
      a = seed;
      seed = nx(seed);
      ld(a, k[0] ? seed : {seed[31:8], a[7:4], seed[3:0]});
    end
    i_ld0_valid <= 1'b0;
    i_ld1_valid <= 1'b0;
    $display("load pairing test ended");
    for (int k = 0; k < 16; k++) begin
      seed = nx(seed);
      miss(32'h0010_0000 + k * 64 + seed[5:0], seed[7], seed[8]);
    end
    @(negedge i_clock) chk(o_miss_ready, 1'b0);
    @(posedge i_clock);
    accept <= 1'b1;
    repeat (30) @(posedge i_clock);
    @(negedge i_clock) chk(o_inflight_lines, `MEM_LIMIT);
    ret <= 1'b1;
    miss(32'h0020_0000, 1'b0, 1'b1);
    for (n = 0; fq.size() > 0 && n < 2000; n++) @(posedge i_clock);
    chk(fq.size(), 0);
    $display("miss tracking test ended");
    st(32'h3008, {seed, ~seed}, 8'h0f);
    st(32'h3030, {~seed, seed}, 8'hf0);
    @(negedge i_clock) chk({o_wcb_addr_q, o_wcb_bytes_q}, {32'h3000, xb});
    chk(o_wcb_data_q & xm, xd);
    @(posedge i_clock);
    {i_st_valid, i_st_addr, i_miss_valid, i_miss_addr, i_miss_prefetch} <=
      {1'b1, 32'h4000, 1'b1, 32'h3020, 1'b1};
    @(negedge i_clock) chk({o_st_ready, o_miss_ready}, 2'b00);
    @(posedge i_clock);
    i_wcb_drain_ready <= 1'b1;
    @(negedge i_clock) chk({o_st_ready, o_miss_ready}, 2'b10);
    @(posedge i_clock);
    {i_st_valid, i_miss_valid} <= 2'b00;
    miss(32'h3020, 1'b1, 1'b0);
    for (n = 0; fq.size() > 0 && n < 500; n++) @(posedge i_clock);
    chk(fq.size(), 0);
    $display("store merge test ended");
    ret <= 1'b0;
    miss(32'h5000, 1'b0, 1'b0);
    miss(32'h5010, 1'b0, 1'b0);
    // The second miss rides on the first one's request and fill.
    void'(fq.pop_back());
    repeat (10) @(posedge i_clock);
    @(negedge i_clock) chk(o_inflight_lines, 1);
    ret <= 1'b1;
    for (n = 0; fq.size() > 0 && n < 200; n++) @(posedge i_clock);
    repeat (3) @(posedge i_clock);
    @(negedge i_clock) chk(o_inflight_lines, 0);
    chk(fq.size(), 0);
    $display("same line test ended");
    final_report();
  end
endmodule
